// ---- verilog/atc_timer.sv ----
// 8-bit timer/counter with two compare channels behind an APB slave.
//
// Our own choices: register access over APB and the placing of the registers.
module atc_timer
	import atc_pkg::*;
(
	input  wire logic        clk_sys_i,
	input  wire logic        sys_rst_i,
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [7:0]  paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	input  wire logic        osc_pin_in_i,
	input  wire logic [2:0]  irq_ack_i,
	output logic             irq_ovf_o,
	output logic             irq_match_a_o,
	output logic             irq_match_b_o,
	output logic             wave_out_a_o,
	output logic             wave_out_b_o
);

	typedef struct packed {
		logic [2:0]  wgm;
		logic [1:0]  com_a;
		logic [1:0]  com_b;
		logic [2:0]  cs;
		logic [7:0]  count;
		logic        dir_down;
		logic        block;
		logic [2:0]  flags;
		logic [2:0]  mask;
		logic        async_sel;
		logic        power_reduce;
		logic [9:0]  pre;
		logic [2:0]  osc_sync;
		logic        osc_lvl;
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
		logic [2:0]  irq;
	} atc_top_s;

	atc_top_s   q, d;
	atc_wgm_e   wgm;
	atc_cls_e   cls;
	logic       wr_acc;
	logic       setup;
	logic       mapped;
	logic       run;
	logic       tick;
	logic       osc_rise;
	logic       wr_cnt;
	logic       ovf_set;
	logic       bottom_ev;
	logic       update_ev;
	logic [7:0] top;
	logic [7:0] rbyte;
	logic [7:0] act_a;
	logic [7:0] rd_a;
	logic [7:0] rd_b;
	logic       set_a;
	logic       set_b;
	logic       wave_a;
	logic       wave_b;
	logic [2:0] w1c;

	always_comb begin
		d = q;
		wgm = atc_wgm_e'(q.wgm);
		unique case (wgm)
			ATC_WGM_PC_MAX, ATC_WGM_PC_CMPA:     cls = ATC_CLS_PC;
			ATC_WGM_FAST_MAX, ATC_WGM_FAST_CMPA: cls = ATC_CLS_FAST;
			ATC_WGM_NORMAL, ATC_WGM_CTC,
			ATC_WGM_RSV4, ATC_WGM_RSV6:          cls = ATC_CLS_NONPWM;
		endcase
		top = (wgm == ATC_WGM_CTC || wgm == ATC_WGM_PC_CMPA || wgm == ATC_WGM_FAST_CMPA)
			? act_a : CNT_MAX;
		setup = psel_i && !penable_i;
		wr_acc = psel_i && penable_i && q.pready && pwrite_i && !q.pslverr;
		mapped = (paddr_i <= OFS_POWER) && (paddr_i[1:0] == 2'b00);

		// Oscillator pin rising edges count once the second and third stages agree.
		d.osc_sync = {q.osc_sync[1:0], osc_pin_in_i};
		if (q.osc_sync[1] == q.osc_sync[2]) begin
			d.osc_lvl = q.osc_sync[2];
		end
		osc_rise = (q.osc_sync[1] == q.osc_sync[2]) && q.osc_sync[2] && !q.osc_lvl;
		run = !q.power_reduce && (q.cs != 3'b000)
			&& (q.async_sel ? osc_rise : 1'b1);
		if (run) begin
			d.pre = q.pre + 10'h001;
		end
		tick = run && ((q.pre & PRE_MASK[q.cs]) == PRE_MASK[q.cs]);

		ovf_set = 1'b0;
		bottom_ev = 1'b0;
		update_ev = 1'b0;
		if (tick) begin
			d.block = 1'b0;
			if (cls == ATC_CLS_PC) begin
				if (!q.dir_down) begin
					if (q.count >= top) begin
						d.dir_down = 1'b1;
						update_ev = 1'b1;
						d.count = (top == CNT_BOTTOM) ? CNT_BOTTOM : q.count - 8'h01;
					end else begin
						d.count = q.count + 8'h01;
					end
				end else if (q.count == CNT_BOTTOM) begin
					d.dir_down = 1'b0;
					ovf_set = 1'b1;
					d.count = (top == CNT_BOTTOM) ? CNT_BOTTOM : 8'h01;
				end else begin
					d.count = q.count - 8'h01;
				end
			end else begin
				d.dir_down = 1'b0;
				if (cls == ATC_CLS_FAST && q.count == top) begin
					d.count = CNT_BOTTOM;
					ovf_set = 1'b1;
					update_ev = 1'b1;
				end else if (wgm == ATC_WGM_CTC && q.count == top) begin
					d.count = CNT_BOTTOM;
					ovf_set = (q.count == CNT_MAX);
				end else begin
					d.count = q.count + 8'h01;
					ovf_set = (q.count == CNT_MAX);
				end
				bottom_ev = (cls == ATC_CLS_FAST) && (d.count == CNT_BOTTOM);
			end
		end

		// A software count write wins over the timer and arms the match block.
		wr_cnt = wr_acc && (paddr_i == OFS_COUNT);
		if (wr_cnt) begin
			d.count = pwdata_i[7:0];
			d.block = 1'b1;
		end

		w1c = (wr_acc && paddr_i == OFS_FLAG) ? pwdata_i[2:0] : 3'b000;
		d.flags = (q.flags & ~w1c & ~irq_ack_i) | {set_b, set_a, ovf_set};
		d.irq = q.flags & q.mask;

		if (wr_acc && paddr_i == OFS_CTRL_A) begin
			d.wgm[1:0] = pwdata_i[CA_WGM_LO +: 2];
			d.com_a = pwdata_i[CA_COMA_LO +: 2];
			d.com_b = pwdata_i[CA_COMB_LO +: 2];
		end
		if (wr_acc && paddr_i == OFS_CTRL_B) begin
			d.wgm[2] = pwdata_i[CB_WGM2];
			d.cs = pwdata_i[CB_CS_LO +: 3];
		end
		if (wr_acc && paddr_i == OFS_MASK) d.mask = pwdata_i[2:0];
		if (wr_acc && paddr_i == OFS_ASYNC) d.async_sel = pwdata_i[AS_SEL];
		if (wr_acc && paddr_i == OFS_POWER) d.power_reduce = pwdata_i[PR_BIT];

		unique case (paddr_i)
			OFS_CTRL_A: rbyte = {q.com_a, q.com_b, 2'b00, q.wgm[1:0]};
			OFS_CTRL_B: rbyte = {4'h0, q.wgm[2], q.cs};
			OFS_COUNT:  rbyte = q.count;
			OFS_CMP_A:  rbyte = rd_a;
			OFS_CMP_B:  rbyte = rd_b;
			OFS_FLAG:   rbyte = {5'h00, q.flags};
			OFS_MASK:   rbyte = {5'h00, q.mask};
			OFS_ASYNC:  rbyte = {2'b00, q.async_sel, 5'h00};
			OFS_POWER:  rbyte = {7'h00, q.power_reduce};
			default:    rbyte = RST_BYTE;
		endcase
		d.pready = setup;
		d.pslverr = setup && !mapped;
		d.prdata = setup ? {24'h000000, rbyte} : 32'h00000000;
	end

	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			q <= '0;
			q.power_reduce <= RST_POWER;
		end else begin
			q <= d;
		end
	end

	atc_cmp_chan u_chan_a (
		.clk_sys_i   (clk_sys_i),
		.sys_rst_i   (sys_rst_i),
		.cls_i       (cls),
		.com_i       (q.com_a),
		.count_i     (q.count),
		.tick_i      (tick),
		.block_i     (q.block),
		.dir_down_i  (q.dir_down),
		.bottom_ev_i (bottom_ev),
		.update_ev_i (update_ev),
		.wr_i        (wr_acc && paddr_i == OFS_CMP_A),
		.wdata_i     (pwdata_i[7:0]),
		.force_i     (wr_acc && paddr_i == OFS_CTRL_B && pwdata_i[CB_FOCA]),
		.active_o    (act_a),
		.rd_o        (rd_a),
		.flag_set_o  (set_a),
		.wave_o      (wave_a)
	);

	atc_cmp_chan u_chan_b (
		.clk_sys_i   (clk_sys_i),
		.sys_rst_i   (sys_rst_i),
		.cls_i       (cls),
		.com_i       (q.com_b),
		.count_i     (q.count),
		.tick_i      (tick),
		.block_i     (q.block),
		.dir_down_i  (q.dir_down),
		.bottom_ev_i (bottom_ev),
		.update_ev_i (update_ev),
		.wr_i        (wr_acc && paddr_i == OFS_CMP_B),
		.wdata_i     (pwdata_i[7:0]),
		.force_i     (wr_acc && paddr_i == OFS_CTRL_B && pwdata_i[CB_FOCB]),
		.active_o    (),
		.rd_o        (rd_b),
		.flag_set_o  (set_b),
		.wave_o      (wave_b)
	);

	assign prdata_o      = q.prdata;
	assign pready_o      = q.pready;
	assign pslverr_o     = q.pslverr;
	assign irq_ovf_o     = q.irq[FL_OVF];
	assign irq_match_a_o = q.irq[FL_MA];
	assign irq_match_b_o = q.irq[FL_MB];
	assign wave_out_a_o  = wave_a;
	assign wave_out_b_o  = wave_b;

	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (sys_rst_i);

	sequence s_count_write;
		wr_cnt;
	endsequence

	sequence s_normal_wrap;
		tick && wgm == ATC_WGM_NORMAL && q.count == CNT_MAX && !wr_cnt;
	endsequence

	AST_STOP_HOLD: assert property ((q.cs == 3'b000 && !wr_cnt) |=> $stable(q.count))
		else $error("Count moved with the timer clock stopped.");
	AST_POWER_OFF: assert property (q.power_reduce |-> !tick)
		else $error("Timer clock ran while power reduced.");
	AST_WRITE_WINS: assert property (s_count_write |=> q.count == $past(pwdata_i[7:0]))
		else $error("Count write did not take priority.");
	AST_MATCH_BLOCK: assert property (s_count_write ##1 (!tick)[*3] ##1 tick
		|-> !set_a && !set_b)
		else $error("Compare match not blocked after a count write.");
	AST_MATCH_FLAG: assert property ((set_a && !irq_ack_i[FL_MA]) |=> q.flags[FL_MA])
		else $error("Match flag A not set after a match.");
	AST_FLAG_CLEAR: assert property ((q.flags[FL_OVF] && w1c[FL_OVF] && !ovf_set)
		|=> !q.flags[FL_OVF])
		else $error("Overflow flag survived a write of one.");
	AST_IRQ_MASK: assert property (##1 q.irq == $past(q.flags & q.mask))
		else $error("Interrupt request does not follow flag and mask.");
	AST_NORMAL_WRAP: assert property (s_normal_wrap |=> q.count == CNT_BOTTOM
		&& q.flags[FL_OVF])
		else $error("Normal mode wrap or overflow flag wrong.");
	AST_CTC_CLEAR: assert property ((tick && wgm == ATC_WGM_CTC && q.count == act_a
		&& !wr_cnt) |=> q.count == CNT_BOTTOM)
		else $error("Clear on match did not clear the count.");
	AST_FAST_RESTART: assert property ((tick && cls == ATC_CLS_FAST && q.count == top
		&& !wr_cnt) |=> q.count == CNT_BOTTOM)
		else $error("Fast mode did not restart at top.");

endmodule : atc_timer

// ---- verilog/atc_pkg.sv ----
// Shared constants and types for the 8-bit timer with two compare channels.
package atc_pkg;

	localparam int unsigned CNT_W = 8;
	localparam int unsigned PRE_W = 10;

	localparam logic [7:0] OFS_CTRL_A = 8'h00;
	localparam logic [7:0] OFS_CTRL_B = 8'h04;
	localparam logic [7:0] OFS_COUNT  = 8'h08;
	localparam logic [7:0] OFS_CMP_A  = 8'h0c;
	localparam logic [7:0] OFS_CMP_B  = 8'h10;
	localparam logic [7:0] OFS_FLAG   = 8'h14;
	localparam logic [7:0] OFS_MASK   = 8'h18;
	localparam logic [7:0] OFS_ASYNC  = 8'h1c;
	localparam logic [7:0] OFS_POWER  = 8'h20;

	localparam int unsigned CA_WGM_LO = 0;
	localparam int unsigned CA_COMB_LO = 4;
	localparam int unsigned CA_COMA_LO = 6;
	localparam int unsigned CB_CS_LO  = 0;
	localparam int unsigned CB_WGM2   = 3;
	localparam int unsigned CB_FOCB   = 6;
	localparam int unsigned CB_FOCA   = 7;
	localparam int unsigned FL_OVF    = 0;
	localparam int unsigned FL_MA     = 1;
	localparam int unsigned FL_MB     = 2;
	localparam int unsigned AS_SEL    = 5;
	localparam int unsigned PR_BIT    = 0;

	localparam logic [7:0] RST_BYTE  = 8'h00;
	localparam logic       RST_POWER = 1'b0;
	localparam logic [7:0] CNT_BOTTOM = 8'h00;
	localparam logic [7:0] CNT_MAX    = 8'hff;

	// Prescaler tap per clock select code; code 0 stops the timer.
	localparam logic [9:0] PRE_MASK [8] = '{10'h000, 10'h000, 10'h007, 10'h01f,
		10'h03f, 10'h07f, 10'h0ff, 10'h3ff};

	localparam logic [1:0] COM_NONE   = 2'b00;
	localparam logic [1:0] COM_TOGGLE = 2'b01;
	localparam logic [1:0] COM_CLEAR  = 2'b10;
	localparam logic [1:0] COM_SET    = 2'b11;

	typedef enum logic [2:0] {
		ATC_WGM_NORMAL   = 3'b000,
		ATC_WGM_PC_MAX   = 3'b001,
		ATC_WGM_CTC      = 3'b010,
		ATC_WGM_FAST_MAX = 3'b011,
		ATC_WGM_RSV4     = 3'b100,
		ATC_WGM_PC_CMPA  = 3'b101,
		ATC_WGM_RSV6     = 3'b110,
		ATC_WGM_FAST_CMPA = 3'b111
	} atc_wgm_e;

	typedef enum logic [1:0] {
		ATC_CLS_NONPWM = 2'b00,
		ATC_CLS_FAST   = 2'b01,
		ATC_CLS_PC     = 2'b10
	} atc_cls_e;

endpackage : atc_pkg

// ---- verilog/atc_cmp_chan.sv ----
// One compare channel: compare buffer, active compare value and output state.
module atc_cmp_chan
	import atc_pkg::*;
(
	input  wire logic       clk_sys_i,
	input  wire logic       sys_rst_i,
	input  wire atc_cls_e   cls_i,
	input  wire logic [1:0] com_i,
	input  wire logic [7:0] count_i,
	input  wire logic       tick_i,
	input  wire logic       block_i,
	input  wire logic       dir_down_i,
	input  wire logic       bottom_ev_i,
	input  wire logic       update_ev_i,
	input  wire logic       wr_i,
	input  wire logic [7:0] wdata_i,
	input  wire logic       force_i,
	output logic [7:0]      active_o,
	output logic [7:0]      rd_o,
	output logic            flag_set_o,
	output logic            wave_o
);

	typedef struct packed {
		logic [7:0] shadow;
		logic [7:0] act;
		logic       wave;
	} atc_chan_s;

	atc_chan_s q, d;
	logic      buffered;
	logic      match;

	always_comb begin
		d = q;
		buffered = (cls_i != ATC_CLS_NONPWM);
		match = tick_i && (count_i == q.act) && !block_i;
		if (buffered && update_ev_i) begin
			d.act = q.shadow;
		end
		if (wr_i) begin
			d.shadow = wdata_i;
			if (!buffered) begin
				d.act = wdata_i;
			end
		end
		// Output mode bits are used live, never buffered with the compare value.
		if (cls_i == ATC_CLS_NONPWM) begin
			if (match || force_i) begin
				case (com_i)
					COM_TOGGLE: d.wave = !q.wave;
					COM_CLEAR:  d.wave = 1'b0;
					COM_SET:    d.wave = 1'b1;
					default:    d.wave = q.wave;
				endcase
			end
		end else if (cls_i == ATC_CLS_FAST) begin
			if (match && com_i == COM_CLEAR) d.wave = 1'b0;
			if (match && com_i == COM_SET) d.wave = 1'b1;
			if (bottom_ev_i && com_i == COM_CLEAR) d.wave = 1'b1;
			if (bottom_ev_i && com_i == COM_SET) d.wave = 1'b0;
		end else begin
			if (match && com_i == COM_CLEAR) d.wave = dir_down_i;
			if (match && com_i == COM_SET) d.wave = !dir_down_i;
		end
	end

	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign active_o = q.act;
	assign rd_o = buffered ? q.shadow : q.act;
	assign flag_set_o = match;
	assign wave_o = q.wave;

	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (sys_rst_i);

	AST_COM_NONE_HOLD: assert property ((com_i == COM_NONE) |=> $stable(q.wave))
		else $error("Output state changed with output mode none.");
	AST_DIRECT_WRITE: assert property ((wr_i && !buffered && !update_ev_i)
		|=> q.act == $past(wdata_i))
		else $error("Unbuffered compare write did not reach the active value.");
	AST_BUF_HOLD: assert property ((buffered && !update_ev_i) |=> $stable(q.act))
		else $error("Active compare value changed outside an update point.");

endmodule : atc_cmp_chan

// ---- testbench/atc_cpu_model.sv ----
// Processor model that services the timer's interrupt requests.
module atc_cpu_model (
	input  wire logic       clk_sys_i,
	input  wire logic       sys_rst_i,
	input  wire logic       enable_i,
	input  wire logic [3:0] delay_i,
	input  wire logic [2:0] irq_i,
	output logic      [2:0] irq_ack_o
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [3:0] wait_q;
	logic [2:0] guard_q;

	// A request falls two cycles after its acknowledge, so the model holds off meanwhile.
	always @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			wait_q <= '0;
			guard_q <= '0;
			irq_ack_o <= '0;
		end else begin
			irq_ack_o <= '0;
			if (guard_q != 3'd0) begin
				guard_q <= guard_q - 3'd1;
				wait_q <= '0;
			end else if (enable_i && irq_i != 3'd0) begin
				if (wait_q >= delay_i) begin
					irq_ack_o <= irq_i;
					guard_q <= 3'd3;
					wait_q <= '0;
				end else begin
					wait_q <= wait_q + 4'd1;
				end
			end else begin
				wait_q <= '0;
			end
		end
	end
endmodule : atc_cpu_model

// ---- testbench/atc_timer_bench.sv ----
// Self-checking bench for the 8-bit timer with two compare channels.
module atc_timer_bench
	import atc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        osc = 1'b0;
	logic [2:0]  ack;
	logic [2:0]  irq;
	logic        wave_a;
	logic        wave_b;
	logic        irq_en = 1'b0;
	logic [3:0]  irq_dly = 4'h0;
	logic        osc_run = 1'b0;
	logic [1:0]  osc_cnt = 2'b00;
	logic [31:0] seed = 32'h3664;
	logic [31:0] rdat;
	logic        rerr;
	int          err_count = 0;
	int          checks = 0;

	atc_timer u_dut (
		.clk_sys_i(clk), .sys_rst_i(rst), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(pslverr), .osc_pin_in_i(osc), .irq_ack_i(ack),
		.irq_ovf_o(irq[0]), .irq_match_a_o(irq[1]), .irq_match_b_o(irq[2]),
		.wave_out_a_o(wave_a), .wave_out_b_o(wave_b)
	);

	atc_cpu_model u_cpu (
		.clk_sys_i(clk), .sys_rst_i(rst), .enable_i(irq_en), .delay_i(irq_dly),
		.irq_i(irq), .irq_ack_o(ack)
	);

	always #50 clk = ~clk;

	// The oscillator pin toggles every fourth system cycle while enabled.
	always @(posedge clk) begin
		if (osc_run) begin
			osc_cnt <= osc_cnt + 2'd1;
			if (osc_cnt == 2'd3) osc <= ~osc;
		end
	end

	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : xs

	function automatic logic next_wave(input logic [1:0] c, input logic cur);
		case (c)
			COM_TOGGLE: return ~cur;
			COM_CLEAR:  return 1'b0;
			COM_SET:    return 1'b1;
			default:    return cur;
		endcase
	endfunction : next_wave

	task automatic finish_test();
		if (err_count == 0 && checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : finish_test

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			$display("BAD %s expected %h seen %h", n, e, g);
			err_count++;
		end
	endtask : chk

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			err_count++;
			finish_test();
		end
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task automatic rd_bit(input string n, input logic [7:0] a, input int b, input logic e);
		apb(1'b0, a, 32'h0);
		chk(n, {31'h0, e}, {31'h0, rdat[b]});
	endtask : rd_bit

	initial begin
		repeat (20000) @(posedge clk);
		err_count++;
		finish_test();
	end

	initial begin
		logic [7:0] v;
		logic [7:0] hold;
		logic [1:0] c;
		logic       wa;
		int         k;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		for (k = 0; k < 9; k++) begin
			apb(1'b0, 8'(4 * k), 32'h0);
			chk("reset value", 32'h0, rdat);
		end
		apb(1'b0, 8'h24, 32'h0);
		chk("unmapped error", 32'h1, {31'h0, rerr});
		v = 8'(xs());
		wr(OFS_COUNT, {24'h0, v});
		repeat (10) @(posedge clk);
		apb(1'b0, OFS_COUNT, 32'h0);
		chk("stopped count", {24'h0, v}, rdat);
		hold = v;
		wr(OFS_CMP_B, {xs()});
		v = pwdata[7:0];
		apb(1'b0, OFS_CMP_B, 32'h0);
		chk("compare width", {24'h0, v}, rdat);
		wr(OFS_POWER, 32'h1);
		wr(OFS_CTRL_B, 32'h1);
		repeat (20) @(posedge clk);
		apb(1'b0, OFS_COUNT, 32'h0);
		chk("power held", {24'h0, hold}, rdat);
		wr(OFS_CTRL_B, 32'h0);
		wr(OFS_POWER, 32'h0);
		wr(OFS_COUNT, 32'hf0);
		wr(OFS_CTRL_B, 32'h1);
		repeat (30) @(posedge clk);
		wr(OFS_CTRL_B, 32'h0);
		rd_bit("overflow flag", OFS_FLAG, FL_OVF, 1'b1);
		chk("masked request", 32'h0, {31'h0, irq[0]});
		wr(OFS_FLAG, 32'h1);
		rd_bit("flag write clear", OFS_FLAG, FL_OVF, 1'b0);
		v = 8'(xs() % 100 + 20);
		wr(OFS_CMP_A, {24'h0, v});
		wr(OFS_COUNT, {24'h0, v - 8'd10});
		wr(OFS_FLAG, 32'h7);
		wr(OFS_MASK, 32'h2);
		irq_dly <= 4'(xs() % 8);
		irq_en <= 1'b1;
		wr(OFS_CTRL_B, 32'h1);
		k = 0;
		while (irq[1] !== 1'b1 && k < 40) begin
			@(posedge clk);
			k++;
		end
		chk("match request", 32'h1, {31'h0, irq[1]});
		chk("masked request b", 32'h0, {31'h0, irq[2]});
		repeat (16) @(posedge clk);
		wr(OFS_CTRL_B, 32'h0);
		irq_en <= 1'b0;
		rd_bit("serviced flag", OFS_FLAG, FL_MA, 1'b0);
		wr(OFS_MASK, 32'h0);
		v = 8'(xs());
		wr(OFS_CMP_A, {24'h0, v});
		wr(OFS_FLAG, 32'h7);
		wr(OFS_COUNT, {24'h0, v});
		wr(OFS_CTRL_B, 32'h1);
		repeat (20) @(posedge clk);
		wr(OFS_CTRL_B, 32'h0);
		rd_bit("blocked match", OFS_FLAG, FL_MA, 1'b0);
		wr(OFS_CTRL_A, 32'h2);
		wr(OFS_CMP_A, 32'h5);
		wr(OFS_COUNT, 32'h0);
		wr(OFS_FLAG, 32'h7);
		wr(OFS_CTRL_B, 32'h1);
		repeat (300) @(posedge clk);
		wr(OFS_CTRL_B, 32'h0);
		apb(1'b0, OFS_COUNT, 32'h0);
		chk("ctc range", 32'h1, {31'h0, rdat <= 32'h5});
		rd_bit("ctc no overflow", OFS_FLAG, FL_OVF, 1'b0);
		wr(OFS_FLAG, 32'h7);
		wa = 1'b0;
		for (k = 0; k < 8; k++) begin
			c = (k < 4) ? 2'(k + 1) : 2'(xs());
			wr(OFS_CTRL_A, {24'h0, c, c, 4'h0});
			wr(OFS_CTRL_B, 32'hc0);
			repeat (2) @(posedge clk);
			wa = next_wave(c, wa);
			chk("forced a", {31'h0, wa}, {31'h0, wave_a});
			chk("forced b", {31'h0, wa}, {31'h0, wave_b});
		end
		rd_bit("force no flag", OFS_FLAG, FL_MA, 1'b0);
		wr(OFS_CTRL_A, 32'h3);
		chk("mode change keeps", {31'h0, wa}, {31'h0, wave_a});
		wr(OFS_CTRL_A, 32'h0);
		wr(OFS_ASYNC, 32'h20);
		wr(OFS_COUNT, 32'h0);
		wr(OFS_CTRL_B, 32'h1);
		osc_run <= 1'b1;
		repeat (80) @(posedge clk);
		osc_run <= 1'b0;
		repeat (10) @(posedge clk);
		apb(1'b0, OFS_COUNT, 32'h0);
		chk("oscillator ticks", 32'ha, rdat);
		// Fast mode with top from compare A, then phase correct with the same top.
		wr(OFS_ASYNC, 32'h0);
		wr(OFS_CTRL_A, 32'h3);
		wr(OFS_CTRL_B, 32'h8);
		wr(OFS_CMP_A, 32'h10);
		apb(1'b0, OFS_CMP_A, 32'h0);
		chk("buffered compare", 32'h10, rdat);
		for (k = 0; k < 2; k++) begin
			wr(OFS_FLAG, 32'h7);
			wr(OFS_COUNT, 32'h0);
			wr(OFS_CTRL_B, 32'h9);
			repeat (27) @(posedge clk);
			wr(OFS_CTRL_B, 32'h8);
			apb(1'b0, OFS_COUNT, 32'h0);
			chk("pwm count", (k == 0) ? 32'h7 : 32'h2, rdat);
			rd_bit("pwm overflow", OFS_FLAG, FL_OVF, k == 0);
			wr(OFS_CTRL_A, 32'h1);
		end
		finish_test();
	end
endmodule : atc_timer_bench
